// [rtl/ccfg_pkg.sv]
// Constants for the clock source configuration control block
`default_nettype none
package ccfg_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] CCFG_ADDR_CLOCK_CONFIGURATION = 8'hF8;
  localparam logic [7:0] CCFG_ADDR_PROC_STATUS = 8'hFF;
  localparam logic [7:0] CCFG_CLOCK_CONFIGURATION_RESET = 8'h00;
  localparam logic [7:0] CCFG_ZERO_BYTE = 8'h00;
  // Every bit of the clock configuration register is writable
  localparam logic [7:0] CCFG_RESERVED_MASK = 8'hFF;
  localparam logic [7:0] CCFG_AUX_PORT_ADDR = 8'h02;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CCFG_BIT_EXT_OSC = 0;
  localparam int CCFG_BIT_CLK_OUT_DIS = 1;
  localparam int CCFG_BIT_PRECISION_USB = 2;
  localparam int CCFG_BIT_LV_RST_DIS = 3;
  localparam int CCFG_WAKE_LSB = 4;
  localparam int CCFG_WAKE_MSB = 6;
  localparam int CCFG_BIT_RESUME_DELAY = 7;
  localparam int CCFG_AUX_BIT_XTAL = 1;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CCFG_CLK_MHZ = 200;
  localparam int CCFG_SHORT_DELAY_US = 128;
  localparam int CCFG_LONG_DELAY_MS = 4;
  localparam int CCFG_INT_DELAY_US = 8;
  localparam int CCFG_INT_START_US = 1;
  localparam int CCFG_SHORT_CYCLES = CCFG_SHORT_DELAY_US * CCFG_CLK_MHZ;
  localparam int CCFG_LONG_CYCLES = CCFG_LONG_DELAY_MS * 1000 * CCFG_CLK_MHZ;
  localparam int CCFG_INT_CYCLES = (CCFG_INT_DELAY_US + CCFG_INT_START_US) * CCFG_CLK_MHZ;
  localparam int CCFG_CNT_W = 20;
  localparam logic [CCFG_CNT_W-1:0] CCFG_CNT_ONE = 20'h00001;
  localparam logic [CCFG_CNT_W-1:0] CCFG_CNT_ZERO = 20'h00000;
  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CCFG_RUN,
    CCFG_OSC_START,
    CCFG_RESUME_WAIT,
    CCFG_SUSPENDED
  } ccfg_state_e;
endpackage
`default_nettype wire

// [rtl/ccfg_clock_source_config_control.sv]
// Clock configuration register, port access and clock switch sequencer
`default_nettype none
module ccfg_clock_source_config_control
  import ccfg_pkg::*;
#(
  parameter int LONG_CYCLES = ccfg_pkg::CCFG_LONG_CYCLES // 4 ms hold-off
) (
  input wire logic ref_clk, // System clock, 200 MHz
  input wire logic reset, // Async, active high; low-voltage or brown-out
  input wire logic watchdog_reset_event, // One-cycle watchdog reset pulse
  input wire logic port_read_instruction, // Port read strobe
  input wire logic port_write_instruction, // Direct port write strobe
  input wire logic indexed_port_write_instruction, // Indexed port write strobe
  input wire logic [7:0] instr_addr, // Address carried in instruction
  input wire logic [7:0] index_reg, // Index register contents
  input wire logic [7:0] acc_in, // Accumulator value to write
  input wire logic suspend_req, // Enter suspend
  input wire logic wake_req, // Wake from suspend
  input wire logic ext_osc_stable, // External oscillator stable
  input wire logic crystal_input_pin, // Crystal input level
  output logic [7:0] read_data, // Data to accumulator
  output logic cpu_stall, // Holds CPU
  output logic ext_osc_en, // External oscillator enable
  output logic int_osc_en, // Internal oscillator enable
  output logic clk_sel_ext, // Chip clock from external source
  output logic crystal_output_pin, // Crystal output drive level
  output logic crystal_output_oe_n, // Low while driven
  output logic crystal_input_pulldown, // Weak pull-down enable
  output logic auxiliary_port_bit_one, // Crystal input level as aux port bit, zero while select bit set
  output logic usb_tune_en, // Precision USB tuning enable
  output logic low_voltage_reset_circuit_en, // Low-voltage reset circuit enable
  output logic [2:0] wake_timer_adjust // Wake-up timer period select
);
  import ccfg_pkg::*;

  logic [7:0] clock_configuration;
  ccfg_state_e state;
  logic [CCFG_CNT_W-1:0] cnt;
  logic ext_mode;
  logic int_clk;
  logic wr_any;
  logic [7:0] wr_addr;
  logic [7:0] next_wr_data;

  // ----------------------------------------------------------
  // Port write decode
  // ----------------------------------------------------------
  // Indexed write adds index to instruction address, wraps in 8 bits
  assign wr_addr = indexed_port_write_instruction ?
                   8'(instr_addr + index_reg) : instr_addr;
  assign wr_any = port_write_instruction | indexed_port_write_instruction;
  // Write mask keeps every bit; a bit made reserved later is cleared here
  assign next_wr_data = acc_in & CCFG_RESERVED_MASK;

  // ----------------------------------------------------------
  // Clock configuration register
  // ----------------------------------------------------------
  // Watchdog clears the register like any reset, but the running mode is kept
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clock_configuration <= CCFG_CLOCK_CONFIGURATION_RESET;
    end else if (watchdog_reset_event) begin
      clock_configuration <= CCFG_CLOCK_CONFIGURATION_RESET;
    end else if (wr_any && wr_addr == CCFG_ADDR_CLOCK_CONFIGURATION) begin
      clock_configuration <= next_wr_data;
    end
  end

  // ----------------------------------------------------------
  // Read path
  // ----------------------------------------------------------
  // Unmapped addresses read zero; other registers live elsewhere
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      read_data <= CCFG_ZERO_BYTE;
    end else if (port_read_instruction) begin
      if (instr_addr == CCFG_ADDR_CLOCK_CONFIGURATION) begin
        read_data <= clock_configuration;
      end else if (instr_addr == CCFG_AUX_PORT_ADDR) begin
        read_data <= {6'h00, auxiliary_port_bit_one, 1'b0};
      end else begin
        read_data <= CCFG_ZERO_BYTE;
      end
    end
  end

  // ----------------------------------------------------------
  // Clock switch sequencer
  // ----------------------------------------------------------
  // A write of one to the select bit starts a switch only from internal mode
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= CCFG_RUN;
      ext_mode <= 1'b0;
      cnt <= CCFG_CNT_ZERO;
    end else begin
      case (state)
        CCFG_RUN: begin
          if (wr_any && wr_addr == CCFG_ADDR_CLOCK_CONFIGURATION
              && acc_in[CCFG_BIT_EXT_OSC] && !ext_mode
              && !watchdog_reset_event) begin // Watchdog drops the write, so no switch
            state <= CCFG_OSC_START;
            ext_mode <= 1'b1;
          end else if (suspend_req) begin
            state <= CCFG_SUSPENDED;
          end
        end
        CCFG_OSC_START: begin
          if (ext_osc_stable) begin
            // Delay starts only once the oscillator is stable
            state <= CCFG_RESUME_WAIT;
            cnt <= clock_configuration[CCFG_BIT_RESUME_DELAY] ?
                   CCFG_CNT_W'(LONG_CYCLES) : CCFG_CNT_W'(CCFG_SHORT_CYCLES);
          end
        end
        CCFG_RESUME_WAIT: begin
          if (cnt <= CCFG_CNT_ONE) begin
            state <= CCFG_RUN;
            cnt <= CCFG_CNT_ZERO;
          end else begin
            cnt <= cnt - CCFG_CNT_ONE;
          end
        end
        CCFG_SUSPENDED: begin
          if (wake_req) begin
            // Wake picks the mode from the stored select bit
            ext_mode <= clock_configuration[CCFG_BIT_EXT_OSC];
            if (clock_configuration[CCFG_BIT_EXT_OSC]) begin
              state <= CCFG_OSC_START;
            end else begin
              state <= CCFG_RESUME_WAIT;
              cnt <= CCFG_CNT_W'(CCFG_INT_CYCLES);
            end
          end
        end
        default: begin
          state <= CCFG_RUN;
        end
      endcase
    end
  end

  // Internal clock selected whenever external mode is not latched; its oscillator is off in suspend
  assign int_clk = !ext_mode;

  // ----------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------
  // All pin and control outputs come from flops to keep them glitch-free
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cpu_stall <= 1'b0;
      ext_osc_en <= 1'b0;
      int_osc_en <= 1'b1;
      clk_sel_ext <= 1'b0;
      crystal_output_pin <= 1'b0;
      crystal_output_oe_n <= 1'b0;
      crystal_input_pulldown <= 1'b1;
      auxiliary_port_bit_one <= 1'b0;
      usb_tune_en <= 1'b0;
      low_voltage_reset_circuit_en <= 1'b1;
      wake_timer_adjust <= 3'h0;
    end else begin
      cpu_stall <= (state != CCFG_RUN);
      ext_osc_en <= ext_mode && state != CCFG_SUSPENDED;
      int_osc_en <= int_clk && state != CCFG_SUSPENDED;
      clk_sel_ext <= ext_mode && state != CCFG_OSC_START;
      // Output disable ignored when external oscillator runs
      crystal_output_pin <= int_clk && clock_configuration[CCFG_BIT_CLK_OUT_DIS];
      crystal_output_oe_n <= ext_mode;
      crystal_input_pulldown <= !clock_configuration[CCFG_BIT_EXT_OSC];
      auxiliary_port_bit_one <= !clock_configuration[CCFG_BIT_EXT_OSC] && crystal_input_pin;
      usb_tune_en <= int_clk && clock_configuration[CCFG_BIT_PRECISION_USB];
      // Low-voltage reset is also off in suspend to save power
      low_voltage_reset_circuit_en <= !clock_configuration[CCFG_BIT_LV_RST_DIS]
                                      && state != CCFG_SUSPENDED;
      wake_timer_adjust <= clock_configuration[CCFG_WAKE_MSB:CCFG_WAKE_LSB];
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  reset_clears_cfg_a: assert property (@(posedge ref_clk)
    $fell(reset) |-> clock_configuration == CCFG_CLOCK_CONFIGURATION_RESET)
    else $error("config not zero after reset");
  direct_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    port_write_instruction && !indexed_port_write_instruction && !watchdog_reset_event
    && instr_addr == CCFG_ADDR_CLOCK_CONFIGURATION
    |=> clock_configuration == ($past(acc_in) & CCFG_RESERVED_MASK))
    else $error("direct write not stored");
  indexed_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    indexed_port_write_instruction && !watchdog_reset_event
    && 8'(instr_addr + index_reg) == CCFG_ADDR_CLOCK_CONFIGURATION
    |=> clock_configuration == ($past(acc_in) & CCFG_RESERVED_MASK))
    else $error("indexed write not stored");
  read_back_a: assert property (@(posedge ref_clk) disable iff (reset)
    port_read_instruction && instr_addr == CCFG_ADDR_CLOCK_CONFIGURATION
    |=> read_data == $past(clock_configuration))
    else $error("read data mismatch");
  watchdog_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    watchdog_reset_event
    |=> !clock_configuration[CCFG_BIT_EXT_OSC] && $stable(ext_mode))
    else $error("watchdog handling wrong");
  no_restart_a: assert property (@(posedge ref_clk) disable iff (reset)
    state == CCFG_RUN && ext_mode |=> state != CCFG_OSC_START)
    else $error("switch restarted while external");
  stall_follows_a: assert property (@(posedge ref_clk) disable iff (reset)
    state != CCFG_RUN |=> cpu_stall)
    else $error("cpu not stalled during switch");
  clear_keeps_mode_a: assert property (@(posedge ref_clk) disable iff (reset)
    ext_mode && state != CCFG_SUSPENDED |=> ext_mode)
    else $error("left external mode outside wake");
  short_delay_a: assert property (@(posedge ref_clk) disable iff (reset)
    state == CCFG_OSC_START && ext_osc_stable && !clock_configuration[CCFG_BIT_RESUME_DELAY]
    |=> cnt == CCFG_CNT_W'(CCFG_SHORT_CYCLES))
    else $error("short resume delay wrong");
  int_wake_a: assert property (@(posedge ref_clk) disable iff (reset)
    state == CCFG_SUSPENDED && wake_req && !clock_configuration[CCFG_BIT_EXT_OSC]
    |=> cnt == CCFG_CNT_W'(CCFG_INT_CYCLES) && !ext_mode)
    else $error("internal wake delay wrong");
  clkout_high_a: assert property (@(posedge ref_clk) disable iff (reset)
    !ext_mode && clock_configuration[CCFG_BIT_CLK_OUT_DIS] |=> crystal_output_pin)
    else $error("crystal output not high");

  switch_cover_c: cover property (@(posedge ref_clk) disable iff (reset)
    state == CCFG_RESUME_WAIT ##1 state == CCFG_RUN && ext_mode);
  wake_int_cover_c: cover property (@(posedge ref_clk) disable iff (reset)
    state == CCFG_SUSPENDED && wake_req && !clock_configuration[CCFG_BIT_EXT_OSC]);
  watchdog_cover_c: cover property (@(posedge ref_clk) disable iff (reset)
    watchdog_reset_event && ext_mode);
  ext_wake_cover_c: cover property (@(posedge ref_clk) disable iff (reset)
    state == CCFG_SUSPENDED && wake_req && clock_configuration[CCFG_BIT_EXT_OSC]);
endmodule
`default_nettype wire

// [verification/clock_source_config_control_tb.sv]
// Self-checking bench for the clock source configuration control block
`default_nettype none
module clock_source_config_control_tb;
  import ccfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  // Long hold-off shortened so the 4 ms path fits the run
  localparam int L = 50;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic wdog_rst = 1'b0;
  logic rd_i = 1'b0;
  logic wr_i = 1'b0;
  logic wx_i = 1'b0;
  logic [7:0] ia = 8'h00;
  logic [7:0] ix = 8'h00;
  logic [7:0] acc = 8'h00;
  logic sus = 1'b0;
  logic wak = 1'b0;
  logic stab = 1'b0;
  logic xin = 1'b0;
  logic [7:0] read_data;
  logic [7:0] v;
  logic cpu_stall, ext_en, int_en, sel_ext, xout, xoe_n, pd, aux, tune, lv_rst_en;
  logic [2:0] wta;
  int n_fail = 0;
  int n_compared = 0;
  ccfg_clock_source_config_control #(.LONG_CYCLES(L)) dut (
    .ref_clk(ref_clk), .reset(reset), .watchdog_reset_event(wdog_rst),
    .port_read_instruction(rd_i), .port_write_instruction(wr_i),
    .indexed_port_write_instruction(wx_i), .instr_addr(ia), .index_reg(ix),
    .acc_in(acc), .suspend_req(sus), .wake_req(wak), .ext_osc_stable(stab),
    .crystal_input_pin(xin), .read_data(read_data), .cpu_stall(cpu_stall),
    .ext_osc_en(ext_en), .int_osc_en(int_en), .clk_sel_ext(sel_ext),
    .crystal_output_pin(xout), .crystal_output_oe_n(xoe_n),
    .crystal_input_pulldown(pd), .auxiliary_port_bit_one(aux), .usb_tune_en(tune),
    .low_voltage_reset_circuit_en(lv_rst_en), .wake_timer_adjust(wta));
  // Free-running 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One port write; strobes drop a full cycle later so back-to-back calls stay clean
  task automatic wr(input logic ind, input logic [7:0] a, input logic [7:0] x,
                    input logic [7:0] d);
    @(negedge ref_clk);
    wr_i = !ind;
    wx_i = ind;
    ia = a;
    ix = x;
    acc = d;
    @(negedge ref_clk);
    wr_i = 1'b0;
    wx_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    rd_i = 1'b1;
    ia = a;
    @(negedge ref_clk);
    rd_i = 1'b0;
    d = read_data;
  endtask
  // Pulse one input high for one cycle: 0 watchdog, 1 suspend, 2 wake
  task automatic pulse(input int sel);
    @(negedge ref_clk);
    case (sel)
      0: wdog_rst = 1'b1;
      1: sus = 1'b1;
      default: wak = 1'b1;
    endcase
    @(negedge ref_clk);
    wdog_rst = 1'b0;
    sus = 1'b0;
    wak = 1'b0;
  endtask
  // Count cycles until the stall lifts, bounded
  task automatic wait_run(input int lim, output int n);
    n = 0;
    while (cpu_stall !== 1'b0 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(CCFG_ADDR_CLOCK_CONFIGURATION, v);
    check(v, 8'h00);
    check(int_en, 8'h01);
    check(pd, 8'h01);
    check(lv_rst_en, 8'h01);
    check(xoe_n, 8'h00);
    check(cpu_stall, 8'h00);
    check(wta, 8'h00);
  endtask
  // Only the assigned register address is written, every bit a defined value
  task automatic t_fields();
    wr(1'b0, 8'hF8, 8'h00, 8'hFA);
    rd(8'hF8, v);
    check(v, 8'hFA);
    check(wta, 8'h07);
    check(lv_rst_en, 8'h00);
    check(xout, 8'h01);
    check(tune, 8'h00);
    wr(1'b1, 8'hF0, 8'h08, 8'h56);
    rd(8'hF8, v);
    check(v, 8'h56);
    check(wta, 8'h05);
    check(tune, 8'h01);
    check(lv_rst_en, 8'h01);
    wr(1'b1, 8'h00, 8'hF8, 8'h00);
    rd(8'hF8, v);
    check(v, 8'h00);
    check(tune, 8'h00);
    check(xout, 8'h00);
    xin = 1'b1;
    rd(CCFG_AUX_PORT_ADDR, v);
    check(v, 8'h02);
    check(aux, 8'h01);
    xin = 1'b0;
    rd(CCFG_AUX_PORT_ADDR, v);
    check(v, 8'h00);
    check(aux, 8'h00);
  endtask
  // Switch to the external source and time the hold-off after start-up
  task automatic t_switch(input logic [7:0] d, input int cnt);
    int n;
    stab = 1'b0;
    wr(1'b0, 8'hF8, 8'h00, d);
    repeat (20) @(negedge ref_clk);
    check(cpu_stall, 8'h01);
    check(ext_en, 8'h01);
    check(int_en, 8'h00);
    check(sel_ext, 8'h00);
    stab = 1'b1;
    wait_run(cnt + 100, n);
    check(8'(n >= cnt && n <= cnt + 6), 8'h01);
    check(sel_ext, 8'h01);
    check(xoe_n, 8'h01);
    check(xout, 8'h00);
    check(pd, 8'h00);
    check(tune, 8'h00);
  endtask
  task automatic t_rewrite();
    wr(1'b0, 8'hF8, 8'h00, 8'h81);
    repeat (3) @(negedge ref_clk);
    check(cpu_stall, 8'h00);
  endtask
  // Wake with the select bit still set goes back through oscillator start-up
  task automatic t_ext_wake();
    int n;
    pulse(1);
    stab = 1'b0;
    @(negedge ref_clk);
    check(ext_en, 8'h00);
    check(lv_rst_en, 8'h00);
    pulse(2);
    repeat (5) @(negedge ref_clk);
    check(cpu_stall, 8'h01);
    check(sel_ext, 8'h00);
    check(ext_en, 8'h01);
    stab = 1'b1;
    wait_run(L + 100, n);
    check(8'(n >= L && n <= L + 6), 8'h01);
    check(sel_ext, 8'h01);
  endtask
  // Watchdog clears the select bit; only a wake or a supply reset brings back the internal clock
  task automatic t_wdr_wake();
    int n;
    pulse(0);
    rd(8'hF8, v);
    check(v, 8'h00);
    check(sel_ext, 8'h01);
    check(ext_en, 8'h01);
    pulse(1);
    repeat (3) @(negedge ref_clk);
    check(cpu_stall, 8'h01);
    check(lv_rst_en, 8'h00);
    pulse(2);
    wait_run(3000, n);
    check(8'(n >= CCFG_INT_CYCLES - 2 && n <= CCFG_INT_CYCLES + 6), 8'h01);
    check(sel_ext, 8'h00);
    check(int_en, 8'h01);
    check(lv_rst_en, 8'h01);
  endtask
  // Supply reset in external mode falls back to the internal clock
  task automatic t_power_reset();
    t_switch(8'h81, L);
    @(negedge ref_clk);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(int_en, 8'h01);
    check(ext_en, 8'h00);
    check(sel_ext, 8'h00);
    check(cpu_stall, 8'h00);
    reset = 1'b0;
    rd(8'hF8, v);
    check(v, 8'h00);
  endtask
  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    t_reset();
    t_fields();
    t_switch(8'h07, CCFG_SHORT_CYCLES);
    t_rewrite();
    t_ext_wake();
    t_wdr_wake();
    t_power_reset();
    end_sim();
  end
  // Run needs about 30k cycles; allow twice that
  initial begin
    #300000;
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
